// File: inc/supervisor_pkg.sv
package supervisor_pkg;

    // -------------------------------------------------------------------------
    // Time base
    // -------------------------------------------------------------------------
    localparam int CLK_MHZ            = 20;
    localparam int CLK_PERIOD_NS      = 50;

    // -------------------------------------------------------------------------
    // Timing in printed units
    // -------------------------------------------------------------------------
    localparam int RELEASE_TIMEOUT_US = 1000;
    localparam int WATCHDOG_PERIOD_US = 6300;
    localparam int ONESHOT_NS         = 2000;
    localparam int KICK_PULSE_NS      = 50;

    // Least time rounds up, longest and nominal times round down
    localparam int RELEASE_CYCLES     = RELEASE_TIMEOUT_US * CLK_MHZ;
    localparam int WATCHDOG_CYCLES    = WATCHDOG_PERIOD_US * CLK_MHZ;
    localparam int ONESHOT_CYCLES     = ONESHOT_NS / CLK_PERIOD_NS;
    localparam int KICK_PULSE_CYCLES  = (KICK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Internal servicing of an open kick input, as a fraction of the period
    localparam int SERVICE_NUM        = 7;
    localparam int SERVICE_DEN        = 8;

    // Synchroniser depth
    localparam int SYNC_STAGES        = 2;

    // -------------------------------------------------------------------------
    // Types
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN,
        ST_ASSERT,
        ST_TIMEOUT
    } phase_e;

    // Levels arriving from pins and analog comparators
    typedef struct packed {
        logic supply_low;      // Supply below supply_trip_level
        logic manual_reset_n;  // Manual reset pin, active low
        logic watchdog_kick;   // Watchdog kick pin level
        logic kick_float;      // Kick pin sensed open or three-stated
        logic line_in;         // Digital level of shared reset line
        logic line_above_arm;  // Line above pullup_arm_level
        logic line_above_hi;   // Line above 0.85 of supply
    } sense_s;

    localparam int SENSE_W = $bits(sense_s);

endpackage

// File: logic/supervisor_reset_watchdog.sv
// Notes on behaviour
// - Supply low asserts reset
// - Hold reset full timeout after supply recovers
// - Manual reset low asserts reset
// - Hold timeout after manual reset releases
// - Steady kick for whole period asserts reset
// - Kick edges and reset clear watchdog counter
// - Open kick input disables watchdog
// - Watchdog expiry also gets full timeout
// - Timeout end releases reset, restarts watchdog
// - High reset output inverts low output
// - Others may pull shared line low
// - Line below arm level sets edge flop
// - Pullup on between arm level and 0.85
// - Pullup off above 0.85 or one-shot end
// - Line held high until forced low
// - Fast rise follows every reset source
// - Passive pullup disconnected while asserting reset
// - Watchdog counter held zero during reset
// - Open kick serviced at seven eighths period
// - Kick pulses of 50 ns count
`timescale 1ns/10ps

module supervisor_reset_watchdog #(
    parameter int REL_CYCLES = supervisor_pkg::RELEASE_CYCLES,
    parameter int WD_CYCLES  = supervisor_pkg::WATCHDOG_CYCLES,
    parameter int OS_CYCLES  = supervisor_pkg::ONESHOT_CYCLES
) (
    input  wire logic                   clk,              // 20 MHz system clock
    input  wire logic                   nrst,             // Async reset, active low
    input  wire supervisor_pkg::sense_s sense_i,          // Pin and comparator levels
    output logic                        reset_n_o,        // Push/pull reset, active low
    output logic                        reset_o,          // Push/pull reset, active high
    output logic                        line_o,           // Shared line drive value
    output logic                        line_oe_n,        // Shared line enable, low drives
    output logic                        passive_pullup_o, // Passive pullup connected
    output logic                        active_pullup_o   // Active fast-rise pullup on
);

    // -------------------------------------------------------------------------
    // Derived widths and counts
    // -------------------------------------------------------------------------
    localparam int REL_W   = $clog2(REL_CYCLES + 1);
    localparam int WD_W    = $clog2(WD_CYCLES + 1);
    localparam int OS_W    = $clog2(OS_CYCLES + 1);
    localparam int WD_SVC  = (WD_CYCLES / supervisor_pkg::SERVICE_DEN)
                             * supervisor_pkg::SERVICE_NUM;

    localparam logic [REL_W-1:0] REL_LAST = REL_W'(REL_CYCLES - 1);
    localparam logic [WD_W-1:0]  WD_LAST  = WD_W'(WD_CYCLES - 1);
    localparam logic [WD_W-1:0]  WD_SERV  = WD_W'(WD_SVC);
    localparam logic [OS_W-1:0]  OS_LAST  = OS_W'(OS_CYCLES - 1);

    localparam supervisor_pkg::sense_s SENSE_INIT = '{
        supply_low:     1'b1,
        manual_reset_n: 1'b1,
        watchdog_kick:  1'b0,
        kick_float:     1'b0,
        line_in:        1'b0,
        line_above_arm: 1'b0,
        line_above_hi:  1'b0
    };

    typedef struct packed {
        supervisor_pkg::phase_e phase;
        logic [REL_W-1:0]       rel_cnt;
        logic [WD_W-1:0]        wd_cnt;
        logic                   kick_prev;
        logic                   edge_armed;
        logic                   pullup_on;
        logic [OS_W-1:0]        os_cnt;
        logic                   rst_n;
        logic                   rst_h;
        logic                   line_drv;
        logic                   oe_n;
        logic                   passive_en;
    } state_s;

    localparam state_s STATE_RESET = '{
        phase:      supervisor_pkg::ST_ASSERT,
        rel_cnt:    '0,
        wd_cnt:     '0,
        kick_prev:  1'b0,
        edge_armed: 1'b1,
        pullup_on:  1'b0,
        os_cnt:     '0,
        rst_n:      1'b0,
        rst_h:      1'b1,
        line_drv:   1'b0,
        oe_n:       1'b0,
        passive_en: 1'b0
    };

    state_s                 st_q;
    state_s                 st_d;
    supervisor_pkg::sense_s s;
    logic                   kick_edge;
    logic                   wd_expire;
    logic                   ext_pull;
    logic                   cause;
    logic                   line_low_arm;

    // -------------------------------------------------------------------------
    // Input synchronisation
    // -------------------------------------------------------------------------
    // two-flop synchronisers
    sync_stages #(
        .WIDTH  (supervisor_pkg::SENSE_W),
        .STAGES (supervisor_pkg::SYNC_STAGES),
        .INIT   (SENSE_INIT)
    ) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    (sense_i),
        .q    (s)
    );

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        kick_edge   = s.watchdog_kick ^ st_q.kick_prev;
        st_d.kick_prev = s.watchdog_kick;
        ext_pull    = st_q.oe_n && !s.line_in;
        wd_expire   = (st_q.phase == supervisor_pkg::ST_RUN) && !s.kick_float
                      && !kick_edge && !ext_pull && (st_q.wd_cnt == WD_LAST);
        // manual reset low is a cause
        cause       = s.supply_low || !s.manual_reset_n || wd_expire;
        line_low_arm = !s.line_above_arm;

        case (st_q.phase)
            supervisor_pkg::ST_RUN: begin
                if (cause) begin
                    st_d.phase = supervisor_pkg::ST_ASSERT;
                end
            end
            supervisor_pkg::ST_ASSERT: begin
                if (!cause) begin
                    st_d.phase   = supervisor_pkg::ST_TIMEOUT;
                    st_d.rel_cnt = '0;
                end
            end
            supervisor_pkg::ST_TIMEOUT: begin
                if (cause) begin
                    st_d.phase = supervisor_pkg::ST_ASSERT;
                end else if (st_q.rel_cnt == REL_LAST) begin
                    st_d.phase = supervisor_pkg::ST_RUN;
                end else begin
                    st_d.rel_cnt = st_q.rel_cnt + REL_W'(1);
                end
            end
            default: begin
                st_d.phase = supervisor_pkg::ST_ASSERT;
            end
        endcase

        // counter held at zero in reset
        if ((st_d.phase != supervisor_pkg::ST_RUN)
            || (st_q.phase != supervisor_pkg::ST_RUN)) begin
            st_d.wd_cnt = '0;
        end else if (kick_edge || ext_pull) begin
            st_d.wd_cnt = '0;
        end else if (s.kick_float && (st_q.wd_cnt >= WD_SERV)) begin
            st_d.wd_cnt = '0;
        end else begin
            st_d.wd_cnt = st_q.wd_cnt + WD_W'(1);
        end

        st_d.rst_n      = (st_d.phase == supervisor_pkg::ST_RUN);
        st_d.rst_h      = !st_d.rst_n;
        st_d.line_drv   = 1'b0;
        st_d.oe_n       = st_d.rst_n;
        st_d.passive_en = st_d.rst_n;

        if (line_low_arm) begin
            st_d.edge_armed = 1'b1;
        end

        if (st_q.pullup_on) begin
            // stop on high level or one-shot end
            if (s.line_above_hi || (st_q.os_cnt == OS_LAST) || !st_d.oe_n
                || line_low_arm) begin
                st_d.pullup_on  = 1'b0;
                st_d.edge_armed = line_low_arm;
            end else begin
                st_d.os_cnt = st_q.os_cnt + OS_W'(1);
            end
        // fire between arm level and 0.85
        end else if (st_q.edge_armed && st_q.oe_n && st_d.oe_n && !line_low_arm) begin
            if (s.line_above_hi) begin
                st_d.edge_armed = 1'b0;
            end else begin
                st_d.pullup_on = 1'b1;
                st_d.os_cnt    = '0;
            end
        end
    end

    // -------------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= STATE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign reset_n_o        = st_q.rst_n;
    assign reset_o          = st_q.rst_h;
    assign line_o           = st_q.line_drv;
    assign line_oe_n        = st_q.oe_n;
    assign passive_pullup_o = st_q.passive_en;
    assign active_pullup_o  = st_q.pullup_on;

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    // Hold lengths above eight cycles are assumed for the repetitions below
    sequence s_cause_gone;
        (st_q.phase == supervisor_pkg::ST_ASSERT) && !cause;
    endsequence

    sequence s_quiet_8;
        (!cause) [*8];
    endsequence

    a_supply_asserts: assert property (@(posedge clk) disable iff (!nrst)
        s.supply_low |=> !reset_n_o)
        else $error("supply low did not assert reset");

    a_release_holds: assert property (@(posedge clk) disable iff (!nrst)
        s_cause_gone ##1 s_quiet_8 |-> !reset_n_o)
        else $error("reset released before timeout");

    a_manual_asserts: assert property (@(posedge clk) disable iff (!nrst)
        !s.manual_reset_n |=> !reset_n_o && line_oe_n == 1'b0)
        else $error("manual reset did not assert reset");

    a_release_count: assert property (@(posedge clk) disable iff (!nrst)
        $rose(reset_n_o) |-> $past(st_q.rel_cnt) == REL_LAST)
        else $error("reset released at wrong count");

    a_wd_expiry: assert property (@(posedge clk) disable iff (!nrst)
        wd_expire |=> !reset_n_o ##1 (st_q.phase == supervisor_pkg::ST_TIMEOUT))
        else $error("watchdog expiry did not start timeout");

    a_wd_edge_clear: assert property (@(posedge clk) disable iff (!nrst)
        kick_edge |=> st_q.wd_cnt == '0)
        else $error("kick edge did not clear watchdog");

    a_wd_float_bound: assert property (@(posedge clk) disable iff (!nrst)
        s.kick_float && st_q.wd_cnt == WD_SERV && reset_n_o |=> st_q.wd_cnt == '0)
        else $error("open kick input not serviced");

    a_wd_restart: assert property (@(posedge clk) disable iff (!nrst)
        $rose(reset_n_o) |-> st_q.wd_cnt == '0 ##1 st_q.wd_cnt <= WD_W'(1))
        else $error("watchdog not restarted after release");

    a_polarity_pair: assert property (@(posedge clk) disable iff (!nrst)
        reset_o == !reset_n_o)
        else $error("reset outputs not complementary");

    a_edge_arm: assert property (@(posedge clk) disable iff (!nrst)
        line_low_arm |=> st_q.edge_armed)
        else $error("edge flop not armed");

    a_pullup_high_off: assert property (@(posedge clk) disable iff (!nrst)
        active_pullup_o && s.line_above_hi |=> !active_pullup_o)
        else $error("active pullup stayed on above high level");

    a_pullup_oneshot: assert property (@(posedge clk) disable iff (!nrst)
        $rose(active_pullup_o) |-> ##[1:OS_CYCLES] !active_pullup_o)
        else $error("active pullup exceeded one-shot");

    a_pullup_released: assert property (@(posedge clk) disable iff (!nrst)
        active_pullup_o |-> line_oe_n)
        else $error("active pullup on while driving line");

    a_passive_off: assert property (@(posedge clk) disable iff (!nrst)
        !line_oe_n |-> !passive_pullup_o)
        else $error("passive pullup connected during reset");

    a_wd_held_zero: assert property (@(posedge clk) disable iff (!nrst)
        !reset_n_o |-> st_q.wd_cnt == '0)
        else $error("watchdog counting during reset");

endmodule

// File: logic/sync_stages.sv
`timescale 1ns/10ps

module sync_stages #(
    parameter int WIDTH  = 1,
    parameter int STAGES = 2,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             clk,    // System clock
    input  wire logic             nrst,   // Async reset, active low
    input  wire logic [WIDTH-1:0] d,      // Asynchronous levels
    output logic      [WIDTH-1:0] q       // Synchronised levels
);

    // -------------------------------------------------------------------------
    // Flop chain
    // -------------------------------------------------------------------------
    // Only the last stage is visible; earlier stages may be metastable
    logic [WIDTH-1:0] chain_q [STAGES];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < STAGES; i++) begin
                chain_q[i] <= INIT;
            end
        end else begin
            chain_q[0] <= d;
            for (int i = 1; i < STAGES; i++) begin
                chain_q[i] <= chain_q[i-1];
            end
        end
    end

    assign q = chain_q[STAGES-1];

endmodule

// File: tb/cpu_reset_model.sv
`timescale 1ns/10ps

module cpu_reset_model #(
    parameter int PULL_CYCLES = 12,  // Four processor clocks of three system clocks
    parameter int WAIT_CYCLES = 6    // Two processor clocks before sampling
) (
    input  wire logic clk,           // System clock
    input  wire logic line_oe_n,     // Supervisor pulls line low when 0
    input  wire logic active_pu,     // Supervisor fast-rise pullup on
    input  wire logic heavy,         // Line load too big to reach the high level
    input  wire logic self_reset,    // Pulse: processor starts its own reset
    output logic      line,          // Digital level of the line
    output logic      above_arm,     // Line above arm level
    output logic      above_hi,      // Line above 0.85 of supply
    output logic      was_external,  // Last reset classified as external
    output logic      busy           // Own reset sequence running
);
    // -------------------------------------------------------------------------
    // Line level, 0..15; passive pullup alone is too slow to meet the sample
    // -------------------------------------------------------------------------
    logic [3:0] level = 4'h0;
    int         cnt   = 0;
    logic       pull;

    initial begin
        busy         = 1'b0;
        was_external = 1'b0;
    end

    assign pull      = busy && (cnt < PULL_CYCLES);
    assign line      = (level >= 4'h7);
    assign above_arm = (level >= 4'h2);
    assign above_hi  = (level >= 4'he);

    always @(negedge clk) begin
        if (pull || line_oe_n !== 1'b1) begin
            level <= 4'h0;
        end else if (heavy && level >= 4'ha) begin
            level <= 4'ha;
        end else if (active_pu === 1'b1 && level <= 4'hc) begin
            level <= level + 4'h3;
        end else if (level != 4'hf) begin
            level <= level + 4'h1;
        end
        if (busy) begin
            cnt <= cnt + 1;
        end
        if (!busy && self_reset) begin
            busy <= 1'b1;
            cnt  <= 0;
        end
        if (busy && cnt == PULL_CYCLES + WAIT_CYCLES) begin
            was_external <= ~line;
            busy         <= 1'b0;
        end
    end
endmodule

// File: tb/tb_supervisor_reset_watchdog.sv
`timescale 1ns/10ps

module tb_supervisor_reset_watchdog;
    localparam int REL = 20;
    localparam int WD  = 64;
    localparam int OS  = 8;

    logic clk = 0, nrst = 0, supply_low = 0, mr_n = 1, kick = 0, kick_float = 0;
    logic self_reset = 0, heavy = 0, kick_en = 1, pu_seen = 0;
    logic line, above_arm, above_hi, was_external, cpu_busy;
    logic reset_n_o, reset_o, line_o, line_oe_n, passive_pullup_o, active_pullup_o;
    logic [7:0] kick_cnt = 8'h00;
    int pu_run = 0, pu_max = 0, fail_count = 0, comparisons = 0;
    supervisor_pkg::sense_s sense;

    // -------------------------------------------------------------------------
    // Clock, wiring, background activity
    // -------------------------------------------------------------------------
    always #25 clk = ~clk;

    assign sense = supervisor_pkg::sense_s'({supply_low, mr_n, kick, kick_float,
                                             line, above_arm, above_hi});

    supervisor_reset_watchdog #(.REL_CYCLES(REL), .WD_CYCLES(WD), .OS_CYCLES(OS)) u_dut (
        .clk(clk), .nrst(nrst), .sense_i(sense), .reset_n_o(reset_n_o), .reset_o(reset_o),
        .line_o(line_o), .line_oe_n(line_oe_n), .passive_pullup_o(passive_pullup_o),
        .active_pullup_o(active_pullup_o));

    cpu_reset_model u_cpu (
        .clk(clk), .line_oe_n(line_oe_n), .active_pu(active_pullup_o), .heavy(heavy),
        .self_reset(self_reset), .line(line), .above_arm(above_arm), .above_hi(above_hi),
        .was_external(was_external), .busy(cpu_busy));

    // Keeps the watchdog quiet between scenarios that do not exercise it
    always @(negedge clk) begin
        kick_cnt <= kick_cnt + 8'h01;
        if (kick_en && kick_cnt[3:0] == 4'hf) begin
            kick <= ~kick;
        end
    end

    always @(negedge clk) begin
        if (active_pullup_o === 1'b1) begin
            pu_seen = 1'b1;
            pu_run  = pu_run + 1;
        end else begin
            pu_run = 0;
        end
        if (pu_run > pu_max) begin
            pu_max = pu_run;
        end
        if (nrst === 1'b1) begin
            check(reset_o, !reset_n_o);
            check(passive_pullup_o, reset_n_o);
        end
    end

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic check_release();
        int n;
        n = 0;
        while (reset_n_o !== 1'b1 && n < 300) begin
            cycles(1);
            n++;
        end
        check(n >= REL && n <= REL + 5, 1'b1);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // -------------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------------
    task automatic t_supply();
        supply_low = 1'b1;
        cycles(4);
        check({reset_n_o, line_oe_n}, 2'h0);
        cycles(10);
        supply_low = 1'b0;
        pu_seen = 1'b0;
        check_release();
        cycles(20);
        check(pu_seen, 1'b1);
    endtask

    task automatic t_manual();
        mr_n = 1'b0;
        cycles(4);
        check(reset_n_o, 1'b0);
        mr_n = 1'b1;
        check_release();
    endtask

    task automatic t_oneshot();
        heavy = 1'b1;
        t_manual();
        pu_seen = 1'b0;
        pu_max  = 0;
        cycles(40);
        check(pu_seen, 1'b1);
        check(pu_max >= OS - 1 && pu_max <= OS + 1, 1'b1);
        check(active_pullup_o, 1'b0);
        heavy = 1'b0;
    endtask

    task automatic t_watchdog();
        int n;
        kick_en = 1'b0;
        t_manual();
        n = 0;
        while (reset_n_o === 1'b1 && n < 200) begin
            cycles(1);
            n++;
        end
        // Line rise after release counts as an outside pull for a few cycles
        check(n >= WD - 2 && n <= WD + 8, 1'b1);
        check_release();
    endtask

    task automatic t_kick_pulses();
        for (int i = 0; i < 5; i++) begin
            cycles(WD / 2);
            kick = ~kick;
            cycles(1);
            kick = ~kick;
            check(reset_n_o, 1'b1);
        end
    endtask

    task automatic t_float();
        kick_float = 1'b1;
        for (int i = 0; i < 4; i++) begin
            cycles(WD);
            check(reset_n_o, 1'b1);
        end
        kick_float = 1'b0;
    endtask

    task automatic t_cpu_self();
        for (int i = 0; i < 3; i++) begin
            self_reset <= 1'b1;
            cycles(1);
            self_reset <= 1'b0;
            cycles(48);
            check(was_external, 1'b0);
            check(reset_n_o, 1'b1);
        end
        kick_en = 1'b1;
    endtask

    task automatic t_cpu_ext();
        mr_n = 1'b0;
        cycles(4);
        self_reset <= 1'b1;
        cycles(1);
        self_reset <= 1'b0;
        cycles(40);
        check(was_external, 1'b1);
        mr_n = 1'b1;
        check_release();
    endtask

    task automatic t_reinit();
        nrst = 1'b0;
        cycles(2);
        check({reset_n_o, reset_o, line_o, line_oe_n, passive_pullup_o, active_pullup_o},
              6'h10);
        nrst = 1'b1;
        check_release();
    endtask

    initial begin
        cycles(12);
        nrst = 1'b1;
        check_release();
        t_supply();
        t_manual();
        t_oneshot();
        t_watchdog();
        t_kick_pulses();
        t_float();
        t_cpu_self();
        t_cpu_ext();
        t_reinit();
        cycles(10);
        report_and_stop();
    end

    // Whole sequence needs about 1000 cycles; cut a hang at 20000
    initial begin
        #(20000 * 50);
        fail_count++;
        report_and_stop();
    end
endmodule
